//--- gas_alarm_sup.v
// Alarm supervisor for a standby generator set controller
// Contract
// (R1) Warnings are advisory; they never touch start, run or stop outputs.
// (R2) Any active alarm selects alarm page and cycles through active alarms; the display skips shutdown bits 12 and 13 (aux analogue 2 and 3).
// (R3) Warnings clear themselves once their fault condition is gone.
// (R4) Shutdowns latch and stop the set until stop and reset pressed.
// (R5) Reset is ignored while the shutdown cause is still present.
// (R6) Delayed alarms like low oil pressure may reset at rest.
// (R7) Battery high warning after supply above threshold for full delay.
// (R8) Battery low warning after supply below threshold for full delay.
// (R9) Coolant pre-alarm gated by arming timer, then above setting warns.
// (R10) Oil pressure pre-alarm gated by arming timer, then below setting warns.
// (R11) Generator low volt and under frequency gated; high and over always.
// (R12) Overspeed and underspeed warnings from speed pre-alarm settings.
// (R13) Engine unit warning over CAN raises warning and shows its code.
// (R14) CAN enabled and no datalink traffic latches data-failure shutdown.
// (R15) Engine unit shutdown over CAN latches shutdown and shows code.
// (R16) Four aux digital inputs each configurable as warning or shutdown.
// (R17) Three aux analogue inputs usable as digital warning or shutdown.
// (R18) Emergency stop is failsafe, open input latches shutdown at once.
// (R19) Fail-to-start shutdown after configured start attempts used up.
// (R20) Fail-to-stop warning when running after stop commanded.
// (R21) Generator voltage above or below shutdown levels latches shutdown.
// (R22) Charge alternator voltage below threshold raises charge warning.
// (R23) Arming timer runs while engine runs, cleared at rest.
`include "gas_regs.vh"
`default_nettype none
module gas_alarm_sup #(
  parameter VW = 12,
  parameter DLY_CYC_PER_MS = `GAS_CLK_HZ / 1000,
  parameter DISP_CYC = `GAS_CLK_HZ / 1000 * `GAS_DISP_MS,
  parameter CAN_TO_CYC = `GAS_CLK_HZ / 1000 * `GAS_CAN_TO_MS,
  parameter ARM_CYC = `GAS_CLK_HZ / 1000 * `GAS_ARM_MS
) (
  input wire clk,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [VW-1:0] bat_volt,
  input wire [VW-1:0] cool_temp,
  input wire [VW-1:0] oil_press,
  input wire [VW-1:0] eng_speed,
  input wire [VW-1:0] gen_volt,
  input wire [VW-1:0] gen_freq,
  input wire [VW-1:0] charge_volt,
  input wire engine_running,
  input wire stop_cmd,
  input wire start_attempts_used,
  input wire estop_closed,
  input wire [3:0] aux_dig,
  input wire [2:0] aux_ana_trip,
  input wire can_rx_valid,
  input wire can_ecu_warn,
  input wire can_ecu_shut,
  input wire [15:0] can_err_code,
  input wire stop_reset_btn,
  output reg shutdown_stop,
  output reg alarm_page,
  output reg [4:0] alarm_show,
  output reg [15:0] ecu_code_show
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg can_en_r;
  reg [VW-1:0] bat_hi_thr_r, bat_lo_thr_r, cool_thr_r, oil_thr_r;
  reg [VW-1:0] os_thr_r, us_thr_r, ghv_w_r, glv_w_r, gof_r, guf_r;
  reg [VW-1:0] ghv_s_r, glv_s_r, chg_thr_r;
  reg [15:0] bat_hi_dly_r, bat_lo_dly_r;
  reg [6:0] aux_shut_r;
  reg [6:0] aux_en_r;
  reg [`GAS_NSHUT-1:0] shut_r;
  reg [`GAS_NWARN-1:0] warn_r;
  reg [31:0] arm_cnt_r, can_cnt_r, disp_cnt_r, bhi_cnt_r, blo_cnt_r;
  reg [15:0] bhi_ms_r, blo_ms_r;
  reg armed_r, sw_reset_r;
  reg [4:0] scan_r;
  // Pack two thresholds into one bus word
  function [31:0] pk;
    input [VW-1:0] a;
    input [VW-1:0] b;
    begin
      pk = {4'h0, a, 4'h0, b};
    end
  endfunction
  // ****************************************************************
  // Avalon slave: one wait state, then answer
  // ****************************************************************
  // A write lands on the edge that sees waitrequest low, as the master expects
  wire req = (avs_read | avs_write) & ~avs_waitrequest;
  wire [4:0] wa = avs_address;
  always @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (wa[3:0])
          `GAS_OFS_CTRL: avs_readdata <= {31'h0, can_en_r};
          `GAS_OFS_THR_BAT: avs_readdata <= pk(bat_hi_thr_r, bat_lo_thr_r);
          `GAS_OFS_DLY_BAT: avs_readdata <= {bat_hi_dly_r, bat_lo_dly_r};
          `GAS_OFS_THR_ENG: avs_readdata <= pk(cool_thr_r, oil_thr_r);
          `GAS_OFS_THR_GEN: avs_readdata <= pk(ghv_w_r, glv_w_r);
          `GAS_OFS_CFG: avs_readdata <= {9'h0, aux_en_r, 9'h0, aux_shut_r};
          `GAS_OFS_WARN: avs_readdata <= {12'h0, warn_r};
          `GAS_OFS_SHUT: avs_readdata <= {18'h0, shut_r};
          `GAS_OFS_ECU: avs_readdata <= {16'h0, ecu_code_show};
          `GAS_OFS_ARM: avs_readdata <= {31'h0, armed_r};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  // Extra thresholds sit behind address bit 4 to keep the map compact
  always @(posedge clk) begin
    if (!rst_n) begin
      can_en_r <= 1'b0;
      bat_hi_thr_r <= {VW{1'b1}};
      bat_lo_thr_r <= {VW{1'b0}};
      bat_hi_dly_r <= 16'h0001;
      bat_lo_dly_r <= 16'h0001;
      cool_thr_r <= {VW{1'b1}};
      oil_thr_r <= {VW{1'b0}};
      ghv_w_r <= {VW{1'b1}};
      glv_w_r <= {VW{1'b0}};
      os_thr_r <= {VW{1'b1}};
      us_thr_r <= {VW{1'b0}};
      gof_r <= {VW{1'b1}};
      guf_r <= {VW{1'b0}};
      ghv_s_r <= {VW{1'b1}};
      glv_s_r <= {VW{1'b0}};
      chg_thr_r <= {VW{1'b0}};
      aux_shut_r <= 7'h00;
      aux_en_r <= 7'h00;
      sw_reset_r <= 1'b0;
    end else begin
      sw_reset_r <= 1'b0;
      if (req & avs_write) begin
        case (wa)
          {1'b0, `GAS_OFS_CTRL}: begin
            can_en_r <= avs_writedata[`GAS_CTRL_CAN_EN];
            sw_reset_r <= avs_writedata[`GAS_CTRL_STOP_RESET];
          end
          {1'b0, `GAS_OFS_THR_BAT}: begin
            bat_hi_thr_r <= avs_writedata[16 +: VW];
            bat_lo_thr_r <= avs_writedata[0 +: VW];
          end
          {1'b0, `GAS_OFS_DLY_BAT}: begin
            bat_hi_dly_r <= avs_writedata[31:16];
            bat_lo_dly_r <= avs_writedata[15:0];
          end
          {1'b0, `GAS_OFS_THR_ENG}: begin
            cool_thr_r <= avs_writedata[16 +: VW];
            oil_thr_r <= avs_writedata[0 +: VW];
          end
          {1'b0, `GAS_OFS_THR_GEN}: begin
            ghv_w_r <= avs_writedata[16 +: VW];
            glv_w_r <= avs_writedata[0 +: VW];
          end
          {1'b0, `GAS_OFS_CFG}: begin
            aux_en_r <= avs_writedata[22:16];
            aux_shut_r <= avs_writedata[6:0];
          end
          {1'b1, `GAS_OFS_THR_BAT}: begin
            os_thr_r <= avs_writedata[16 +: VW];
            us_thr_r <= avs_writedata[0 +: VW];
          end
          {1'b1, `GAS_OFS_DLY_BAT}: begin
            gof_r <= avs_writedata[16 +: VW];
            guf_r <= avs_writedata[0 +: VW];
          end
          {1'b1, `GAS_OFS_THR_ENG}: begin
            ghv_s_r <= avs_writedata[16 +: VW];
            glv_s_r <= avs_writedata[0 +: VW];
          end
          {1'b1, `GAS_OFS_THR_GEN}: chg_thr_r <= avs_writedata[0 +: VW];
          default: sw_reset_r <= 1'b0;
        endcase
      end
    end
  end
  // ****************************************************************
  // Arming timer, battery delays, datalink watchdog
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      arm_cnt_r <= 32'h0;
      armed_r <= 1'b0;
      can_cnt_r <= 32'h0;
      bhi_cnt_r <= 32'h0;
      blo_cnt_r <= 32'h0;
      bhi_ms_r <= 16'h0;
      blo_ms_r <= 16'h0;
    end else begin
      if (!engine_running) begin // [R23]
        arm_cnt_r <= 32'h0;
        armed_r <= 1'b0;
      end else if (arm_cnt_r >= ARM_CYC - 1) begin
        armed_r <= 1'b1;
      end else begin
        arm_cnt_r <= arm_cnt_r + 32'h1;
      end
      if (!can_en_r || can_rx_valid) can_cnt_r <= 32'h0;
      else if (can_cnt_r < CAN_TO_CYC) can_cnt_r <= can_cnt_r + 32'h1;
      // Millisecond delay counts restart on any sample back inside limits
      if (bat_volt <= bat_hi_thr_r) begin // [R7]
        bhi_cnt_r <= 32'h0;
        bhi_ms_r <= 16'h0;
      end else if (bhi_ms_r < bat_hi_dly_r) begin
        if (bhi_cnt_r >= DLY_CYC_PER_MS - 1) begin
          bhi_cnt_r <= 32'h0;
          bhi_ms_r <= bhi_ms_r + 16'h1;
        end else bhi_cnt_r <= bhi_cnt_r + 32'h1;
      end
      if (bat_volt >= bat_lo_thr_r) begin // [R8]
        blo_cnt_r <= 32'h0;
        blo_ms_r <= 16'h0;
      end else if (blo_ms_r < bat_lo_dly_r) begin
        if (blo_cnt_r >= DLY_CYC_PER_MS - 1) begin
          blo_cnt_r <= 32'h0;
          blo_ms_r <= blo_ms_r + 16'h1;
        end else blo_cnt_r <= blo_cnt_r + 32'h1;
      end
    end
  end
  // ****************************************************************
  // Warning and shutdown conditions, level-following (warnings self-clearing)
  // ****************************************************************
  reg [`GAS_NWARN-1:0] w_nxt;
  reg [`GAS_NSHUT-1:0] s_cond, s_delayed;
  integer i;
  always @* begin
    w_nxt = {`GAS_NWARN{1'b0}};
    w_nxt[`GAS_W_BAT_HI] = (bhi_ms_r >= bat_hi_dly_r) && (bat_volt > bat_hi_thr_r); // [R7]
    w_nxt[`GAS_W_BAT_LO] = (blo_ms_r >= bat_lo_dly_r) && (bat_volt < bat_lo_thr_r); // [R8]
    w_nxt[`GAS_W_ECU] = can_en_r & can_ecu_warn; // [R13]
    w_nxt[`GAS_W_CHARGE] = engine_running && (charge_volt < chg_thr_r); // [R22]
    w_nxt[`GAS_W_FAIL_STOP] = stop_cmd & engine_running; // [R20]
    w_nxt[`GAS_W_GEN_HV] = gen_volt > ghv_w_r; // [R11]
    w_nxt[`GAS_W_GEN_LV] = armed_r && (gen_volt < glv_w_r); // [R11]
    w_nxt[`GAS_W_COOL_HI] = armed_r && (cool_temp > cool_thr_r); // [R9]
    w_nxt[`GAS_W_OIL_LO] = armed_r && (oil_press < oil_thr_r); // [R10]
    w_nxt[`GAS_W_OVER_F] = gen_freq > gof_r; // [R11]
    w_nxt[`GAS_W_UNDER_F] = armed_r && (gen_freq < guf_r); // [R11]
    w_nxt[`GAS_W_OVER_S] = eng_speed > os_thr_r; // [R12]
    w_nxt[`GAS_W_UNDER_S] = eng_speed < us_thr_r; // [R12]
    s_cond = {`GAS_NSHUT{1'b0}};
    s_delayed = {`GAS_NSHUT{1'b0}};
    for (i = 0; i < 4; i = i + 1) begin
      w_nxt[`GAS_W_AUXD + i] = aux_en_r[i] & ~aux_shut_r[i] & aux_dig[i]; // [R16]
      s_cond[`GAS_S_AUXD + i] = aux_en_r[i] & aux_shut_r[i] & aux_dig[i]; // [R16]
    end
    for (i = 0; i < 3; i = i + 1) begin
      w_nxt[`GAS_W_AUXA + i] = aux_en_r[4+i] & ~aux_shut_r[4+i] & aux_ana_trip[i]; // [R17]
      s_cond[`GAS_S_AUXA + i] = aux_en_r[4+i] & aux_shut_r[4+i] & aux_ana_trip[i]; // [R17]
    end
    s_cond[`GAS_S_DATA_FAIL] = can_en_r && (can_cnt_r >= CAN_TO_CYC); // [R14]
    s_cond[`GAS_S_ECU] = can_en_r & can_ecu_shut; // [R15]
    s_cond[`GAS_S_ESTOP] = ~estop_closed; // [R18]
    s_cond[`GAS_S_FAIL_START] = start_attempts_used & ~engine_running; // [R19]
    s_cond[`GAS_S_GEN_HV] = gen_volt > ghv_s_r; // [R21]
    s_cond[`GAS_S_GEN_LV] = armed_r && (gen_volt < glv_s_r); // [R21]
    s_cond[`GAS_S_OIL_LO] = armed_r && (oil_press < oil_thr_r) && (cool_temp > 0); // [R6]
    // Delayed alarms persist at rest, so they must not block the reset
    s_delayed[`GAS_S_OIL_LO] = 1'b1; // [R6]
    s_delayed[`GAS_S_GEN_LV] = 1'b1; // [R6]
    s_delayed[`GAS_S_FAIL_START] = 1'b1; // [R6]
  end
  // ****************************************************************
  // Alarm state and latches
  // ****************************************************************
  wire rst_req = stop_reset_btn | sw_reset_r;
  // A reset clears only those latches whose cause has gone; a cause still present relatches, delayed or not
  wire [`GAS_NSHUT-1:0] clr_ok = ~s_cond | s_delayed; // [R5]
  wire [`GAS_NSHUT-1:0] s_nxt = (rst_req ? (shut_r & ~clr_ok) : shut_r) | s_cond; // [R4]
  wire any_alarm = |warn_r | |shut_r;
  wire [31:0] act = {12'h0, warn_r} | ({18'h0, shut_r} << 20);
  always @(posedge clk) begin
    if (!rst_n) begin
      warn_r <= {`GAS_NWARN{1'b0}};
      shut_r <= {`GAS_NSHUT{1'b0}};
      shutdown_stop <= 1'b0;
      alarm_page <= 1'b0;
      alarm_show <= 5'h00;
      scan_r <= 5'h00;
      disp_cnt_r <= 32'h0;
      ecu_code_show <= 16'h0;
    end else begin
      warn_r <= w_nxt; // [R3]
      shut_r <= s_nxt; // [R4]
      shutdown_stop <= |s_nxt; // [R1] [R4] [R18]
      alarm_page <= any_alarm; // [R2]
      if (can_en_r & (can_ecu_warn | can_ecu_shut)) ecu_code_show <= can_err_code; // [R13] [R15]
      // Dwell on each active alarm, then step to the next set bit
      if (!any_alarm) begin
        disp_cnt_r <= 32'h0;
      end else if (disp_cnt_r >= DISP_CYC - 1 || !act[scan_r]) begin // [R2]
        disp_cnt_r <= 32'h0;
        scan_r <= scan_r + 5'h01;
      end else begin
        disp_cnt_r <= disp_cnt_r + 32'h1;
        alarm_show <= scan_r;
      end
    end
  end
endmodule
`default_nettype wire

//--- gas_alarm_sup_checker.sv
// Port-level assertions of the alarm supervisor
`default_nettype none
module gas_alarm_sup_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic estop_closed,
  input wire logic start_attempts_used,
  input wire logic engine_running,
  input wire logic stop_cmd,
  input wire logic stop_reset_btn,
  input wire logic can_ecu_warn,
  input wire logic [15:0] can_err_code,
  input wire logic shutdown_stop,
  input wire logic alarm_page,
  input wire logic [15:0] ecu_code_show
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Bus and alarm relations
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic req = avs_read | avs_write;
  wait_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");
  estop_shut_a: assert property (!estop_closed |-> ##[1:2] shutdown_stop)
    else $error("open emergency stop did not stop the set");
  estop_keep_a: assert property (!estop_closed && shutdown_stop |=> shutdown_stop)
    else $error("shutdown cleared while emergency stop still open");
  // Two cycles of history cover the latency of a reset request from pin or bus
  shut_hold_a: assert property (shutdown_stop && !stop_reset_btn && !avs_write
    && !$past(stop_reset_btn) && !$past(stop_reset_btn, 2) && !$past(avs_write)
    && !$past(avs_write, 2) |=> shutdown_stop)
    else $error("shutdown cleared without a reset request");
  shut_page_a: assert property (shutdown_stop && $past(shutdown_stop) |-> alarm_page)
    else $error("latched shutdown not on the alarm page");
  fail_start_a: assert property (start_attempts_used && !engine_running
    |-> ##[1:2] shutdown_stop)
    else $error("fail to start did not stop the set");
  fail_stop_a: assert property (stop_cmd && engine_running && $past(stop_cmd)
    && $past(engine_running) |-> ##[0:2] alarm_page)
    else $error("running after stop gave no alarm");
  ecu_code_a: assert property (can_ecu_warn && $past(can_ecu_warn)
    && $stable(can_err_code) |=> ecu_code_show == $past(can_err_code))
    else $error("engine unit code not shown");
  estop_c: cover property (!estop_closed ##1 shutdown_stop);
  ecu_c: cover property (can_ecu_warn && alarm_page);
  bus_c: cover property (req && !avs_waitrequest);
endmodule
bind gas_alarm_sup gas_alarm_sup_checker chk_u (.*);
`default_nettype wire

//--- gas_alarm_sup_tb.sv
// Self-checking bench of the generator set alarm supervisor
`default_nettype none
module gas_alarm_sup_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Signals and instances
  // ****************
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [4:0] avs_address = 5'h00, alarm_show;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [11:0] bat_volt = 12'h400, cool_temp = 12'h400, oil_press = 12'h400, v;
  logic [11:0] eng_speed = 12'h400, gen_volt = 12'h800, gen_freq = 12'h400;
  logic [11:0] charge_volt = 12'hfff;
  logic engine_running = 1'b0, stop_cmd = 1'b0, start_attempts_used = 1'b0;
  logic estop_closed = 1'b1, stop_reset_btn = 1'b0, shutdown_stop, alarm_page;
  logic can_rx_valid, can_ecu_warn, can_ecu_shut;
  logic alive = 1'b0, slow = 1'b0, warn_req = 1'b0, shut_req = 1'b0;
  logic [3:0] aux_dig = 4'h0;
  logic [2:0] aux_ana_trip = 3'h0;
  logic [6:0] sc;
  logic [15:0] code_req = 16'h0, can_err_code, ecu_code_show;
  int n_errors = 0, tests_run = 0, i;
  always #10 clk = ~clk;
  gas_alarm_sup #(.VW(12), .DLY_CYC_PER_MS(2), .DISP_CYC(4), .CAN_TO_CYC(20), .ARM_CYC(10))
    dut_u (.*);
  gas_ecu_model ecu_u (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // Holds the request until waitrequest is sampled low; a bounded wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
  endtask
  task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic press;
    stop_reset_btn <= 1'b1;
    wt(1);
    stop_reset_btn <= 1'b0;
    wt(3);
  endtask
  function automatic logic [31:0] bat_exp(input logic [11:0] x);
    return {30'h0, x < 12'h100, x > 12'h800};
  endfunction
  task results;
    $display("tests %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    $display("unexpected watchdog expected done seen hang");
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(84));
    wt(2);
    rst_n <= 1'b1;
    rc("warn", 5'h06, 32'hfffff, 32'h0);
    rc("shut", 5'h07, 32'h3fff, 32'h0);
    rc("unmapped", 5'h0f, 32'hffffffff, 32'h0);
    $display("test reset done");
    bus(1'b1, 5'h01, {16'h0800, 16'h0100});
    bus(1'b1, 5'h02, {16'd5, 16'd5});
    for (i = 0; i < 2; i++) begin
      v = (i == 0) ? 12'h801 + 12'($urandom % 2046) : 12'($urandom % 256);
      bat_volt <= v;
      wt(4);
      bat_volt <= 12'h400;
      rc("bat_short", 5'h06, 32'h3, 32'h0);
      bat_volt <= v;
      wt(20);
      rc("bat_long", 5'h06, 32'h3, bat_exp(v));
      chk("stop_warn", 32'h0, {31'h0, shutdown_stop});
      bat_volt <= 12'h400;
      wt(3);
      rc("bat_clear", 5'h06, 32'h3, 32'h0);
    end
    $display("test battery done");
    bus(1'b1, 5'h03, {16'h0600, 16'h0200});
    bus(1'b1, 5'h04, {16'h0c00, 16'h0300});
    cool_temp <= 12'hfff;
    oil_press <= 12'h000;
    gen_volt <= 12'hfff;
    wt(3);
    rc("rest", 5'h06, 32'h1e0, 32'h20);
    gen_volt <= 12'h000;
    engine_running <= 1'b1;
    rc("arming", 5'h06, 32'h1e0, 32'h0);
    wt(15);
    rc("armed", 5'h09, 32'h1, 32'h1);
    rc("armed_warn", 5'h06, 32'h1e0, 32'h1c0);
    engine_running <= 1'b0;
    wt(3);
    rc("disarm", 5'h09, 32'h1, 32'h0);
    rc("disarm_warn", 5'h06, 32'h1e0, 32'h0);
    press();
    chk("delayed", 32'h0, {31'h0, shutdown_stop});
    cool_temp <= 12'h400;
    oil_press <= 12'h400;
    gen_volt <= 12'h800;
    $display("test arming done");
    bus(1'b1, 5'h11, {16'h0900, 16'h0100});
    bus(1'b1, 5'h12, {16'h0900, 16'h0100});
    for (i = 0; i < 4; i++) begin
      eng_speed <= (i == 0) ? 12'ha00 : (i == 1) ? 12'h050 : 12'h400;
      gen_freq <= (i == 2) ? 12'ha00 : (i == 3) ? 12'h050 : 12'h400;
      wt(2);
      rc("spd_freq", 5'h06, 32'h1e00, (i < 2) ? 32'h800 << i : (i == 2) ? 32'h200 : 0);
    end
    eng_speed <= 12'h400;
    gen_freq <= 12'h400;
    stop_cmd <= 1'b1;
    engine_running <= 1'b1;
    wt(3);
    rc("fail_stop", 5'h06, 32'h10, 32'h10);
    chk("page", 32'h1, {31'h0, alarm_page});
    wt(40);
    chk("show", 32'h4, {27'h0, alarm_show});
    stop_cmd <= 1'b0;
    engine_running <= 1'b0;
    $display("test speed done");
    estop_closed <= 1'b0;
    wt(3);
    rc("estop", 5'h07, 32'h4, 32'h4);
    press();
    chk("estop_hold", 32'h1, {31'h0, shutdown_stop});
    estop_closed <= 1'b1;
    press();
    chk("estop_clr", 32'h0, {31'h0, shutdown_stop});
    start_attempts_used <= 1'b1;
    wt(3);
    rc("fail_start", 5'h07, 32'h8, 32'h8);
    start_attempts_used <= 1'b0;
    press();
    chk("fs_clr", 32'h0, {31'h0, shutdown_stop});
    $display("test shutdown done");
    sc = 7'($urandom);
    bus(1'b1, 5'h05, {9'h0, 7'h7f, 9'h0, sc});
    for (i = 0; i < 7; i++) begin
      if (i < 4) aux_dig <= 4'(1 << i);
      else aux_ana_trip <= 3'(1 << (i - 4));
      wt(3);
      rc("aux_warn", 5'h06, 32'hfe000, sc[i] ? 0 : 32'h2000 << i);
      rc("aux_shut", 5'h07, 32'h3f80, sc[i] ? 32'h80 << i : 0);
      chk("aux_page", 32'h1, {31'h0, alarm_page});
      aux_dig <= 4'h0;
      aux_ana_trip <= 3'h0;
      bus(1'b1, 5'h00, 32'h2);
      wt(2);
      chk("aux_clr", 32'h0, {31'h0, shutdown_stop});
    end
    $display("test aux done");
    alive <= 1'b1;
    slow <= 1'b1;
    bus(1'b1, 5'h00, 32'h1);
    wt(40);
    rc("can_ok", 5'h07, 32'h3, 32'h0);
    code_req <= 16'($urandom);
    warn_req <= 1'b1;
    wt(4);
    rc("ecu_warn", 5'h06, 32'h4, 32'h4);
    chk("ecu_code", {16'h0, code_req}, {16'h0, ecu_code_show});
    warn_req <= 1'b0;
    shut_req <= 1'b1;
    wt(4);
    rc("ecu_shut", 5'h07, 32'h2, 32'h2);
    shut_req <= 1'b0;
    slow <= 1'b0;
    bus(1'b1, 5'h00, 32'h3);
    wt(2);
    chk("ecu_clr", 32'h0, {31'h0, shutdown_stop});
    alive <= 1'b0;
    wt(30);
    rc("data_fail", 5'h07, 32'h1, 32'h1);
    chk("df_stop", 32'h1, {31'h0, shutdown_stop});
    bus(1'b1, 5'h00, 32'h2);
    $display("test datalink done");
    results();
  end
endmodule
`default_nettype wire

//--- gas_ecu_model.sv
// Engine control unit stand-in on the CAN datalink
`default_nettype none
module gas_ecu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alive,
  input wire logic slow,
  input wire logic warn_req,
  input wire logic shut_req,
  input wire logic [15:0] code_req,
  output logic can_rx_valid,
  output logic can_ecu_warn,
  output logic can_ecu_shut,
  output logic [15:0] can_err_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Frames and reports
  // ****************
  logic [3:0] cnt_r;
  // Slow mode spaces frames 16 cycles apart, still inside the datalink timeout
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      can_rx_valid <= 1'b0;
      can_ecu_warn <= 1'b0;
      can_ecu_shut <= 1'b0;
      can_err_code <= 16'h5a5a;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      can_rx_valid <= alive && (slow ? cnt_r == 4'h0 : cnt_r[2:0] == 3'h0);
      can_ecu_warn <= alive && warn_req;
      can_ecu_shut <= alive && shut_req;
      // Without a report the code churns, so a stale code cannot pass
      can_err_code <= (warn_req || shut_req) ? code_req : ~can_err_code;
    end
  end
endmodule
`default_nettype wire

//--- gas_regs.vh
// Register offsets, field positions and timing constants of the alarm supervisor
`ifndef GAS_REGS_VH
`define GAS_REGS_VH
// ****************************************************************
// Register word offsets (word address = offset)
// ****************************************************************
`define GAS_OFS_CTRL 4'h0
`define GAS_OFS_THR_BAT 4'h1
`define GAS_OFS_DLY_BAT 4'h2
`define GAS_OFS_THR_ENG 4'h3
`define GAS_OFS_THR_GEN 4'h4
`define GAS_OFS_CFG 4'h5
`define GAS_OFS_WARN 4'h6
`define GAS_OFS_SHUT 4'h7
`define GAS_OFS_ECU 4'h8
`define GAS_OFS_ARM 4'h9
// ****************************************************************
// Control register bits
// ****************************************************************
`define GAS_CTRL_CAN_EN 0
`define GAS_CTRL_STOP_RESET 1
// ****************************************************************
// Warning bit positions
// ****************************************************************
`define GAS_W_BAT_HI 0
`define GAS_W_BAT_LO 1
`define GAS_W_ECU 2
`define GAS_W_CHARGE 3
`define GAS_W_FAIL_STOP 4
`define GAS_W_GEN_HV 5
`define GAS_W_GEN_LV 6
`define GAS_W_COOL_HI 7
`define GAS_W_OIL_LO 8
`define GAS_W_OVER_F 9
`define GAS_W_UNDER_F 10
`define GAS_W_OVER_S 11
`define GAS_W_UNDER_S 12
`define GAS_W_AUXD 13
`define GAS_W_AUXA 17
`define GAS_NWARN 20
// ****************************************************************
// Shutdown bit positions
// ****************************************************************
`define GAS_S_DATA_FAIL 0
`define GAS_S_ECU 1
`define GAS_S_ESTOP 2
`define GAS_S_FAIL_START 3
`define GAS_S_GEN_HV 4
`define GAS_S_GEN_LV 5
`define GAS_S_OIL_LO 6
`define GAS_S_AUXD 7
`define GAS_S_AUXA 11
`define GAS_NSHUT 14
// ****************************************************************
// Timing
// ****************************************************************
`define GAS_CLK_HZ 50000000
`define GAS_DISP_MS 2000
`define GAS_CAN_TO_MS 1000
`define GAS_ARM_MS 10000
`endif
